// ### core/rpd_top.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module rpd_top (
  input wire logic CORE_CLK,                      // 10 MHz core clock
  input wire logic RSTN,                          // Async reset, low
  input wire logic CE,                            // Clock enable
  input wire logic PSEL,                          // APB select
  input wire logic PENABLE,                       // APB access phase
  input wire logic PWRITE,                        // APB direction
  input wire logic [rpd_pkg::APB_AW-1:0] PADDR,   // APB byte address
  input wire logic [31:0] PWDATA,                 // APB write data
  output logic [31:0] PRDATA,                     // APB read data
  output logic PREADY,                            // APB ready
  output logic PSLVERR,                           // APB error
  output logic DMA_REQ,                           // DMA request pin
  input wire logic DMA_ACK,                       // DMA acknowledge pin
  input wire logic [15:0] DMA_DIN,                // DMA data in
  output rpd_pkg::rpd_dbus_t DMA_DOUT,            // DMA data out and oe
  output logic IRQ                                // Level interrupt
);
  import rpd_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  rpd_hi_t hi;
  logic [7:0] lo;
  rpd_cfg_t cfg;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] left;
  logic [INT_W-1:0] status;
  logic [INT_W-1:0] int_en;
  logic [7:0] ram [0:(1<<ADDR_W)-1];
  rpd_dma_t state;
  logic en_q;

  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] odd_a;
  logic [ADDR_W-1:0] next_ptr;
  logic odd_high;
  logic [15:0] rword;
  logic [7:0] wr_even;
  logic [7:0] wr_odd;
  logic [15:0] wsrc;
  logic dma_xfer;
  logic cpu_xfer;
  logic xfer;
  logic xfer_wr;
  logic last;
  logic hw_done;
  logic done_src;
  logic done_evt;
  logic [31:0] rdata;

  assign setup = CE & PSEL & ~PENABLE;
  assign wr = CE & PSEL & PENABLE & PWRITE;
  assign rd = CE & PSEL & PENABLE & ~PWRITE;

  // ----------------------------------------------------------------
  // Pointer and byte lanes
  // ----------------------------------------------------------------
  assign ptr = {hi.upper, lo}; // RL10 RL11 RL17
  // Wide mode: bit 0 is the swap bit, so words sit at even addresses
  assign base = cfg.wide ? {ptr[ADDR_W-1:1], 1'b0} : ptr; // RL12
  assign odd_a = {ptr[ADDR_W-1:1], 1'b1};
  assign odd_high = ~(lo[0] ^ cfg.ds_mode); // RL15 RL14

  always_comb begin
    if (!cfg.wide) begin
      rword = {8'h00, ram[base]};
    end else if (odd_high) begin
      rword = {ram[odd_a], ram[base]};
    end else begin
      rword = {ram[base], ram[odd_a]};
    end
  end

  assign wsrc = dma_xfer ? DMA_DIN : PWDATA[15:0]; // RL14
  always_comb begin
    if (!cfg.wide) begin
      wr_even = wsrc[7:0];
      wr_odd = 8'h00;
    end else if (odd_high) begin
      wr_even = wsrc[7:0];
      wr_odd = wsrc[15:8];
    end else begin
      wr_even = wsrc[15:8];
      wr_odd = wsrc[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Data accesses
  // ----------------------------------------------------------------
  // DMA wins over a host data access in the same cycle; the host cycle
  // is then dropped, so software should not touch data during DMA.
  assign dma_xfer = CE & (state == DMA_WAIT) & hi.dma_en & DMA_ACK; // RL18
  assign cpu_xfer = (PADDR == OFS_DATA) & ~dma_xfer &
                    ((wr & ~hi.dir) | (rd & hi.dir)); // RL1
  assign xfer = dma_xfer | cpu_xfer;
  assign xfer_wr = xfer & ~hi.dir; // RL1

  always_comb begin
    if (cfg.wide) begin
      next_ptr = {ptr[ADDR_W-1:1] + 10'h001, lo[0]}; // RL17 RL12
    end else begin
      next_ptr = ptr + 11'h001; // RL17
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (xfer_wr) begin
      ram[base] <= wr_even; // RL18
      if (cfg.wide) begin
        ram[odd_a] <= wr_odd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pointer registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hi <= HI_RST; // RL4
      lo <= LO_RST;
    end else if (CE) begin
      if (wr && PADDR == OFS_PTR_HI) begin
        hi.dir <= PWDATA[7];
        hi.adv <= PWDATA[6];
        hi.dma_en <= PWDATA[3];
        hi.upper <= PWDATA[2:0];
      end else if (hw_done) begin
        hi.dma_en <= 1'b0; // RL8
      end
      if (wr && PADDR == OFS_PTR_LO) begin
        lo <= PWDATA[7:0];
      end else if (xfer && hi.adv && !(wr && PADDR == OFS_PTR_HI)) begin
        hi.upper <= next_ptr[ADDR_W-1:8]; // RL2
        lo <= next_ptr[7:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg <= CFG_RST;
      count <= CNT_RST;
    end else if (CE) begin
      if (wr && PADDR == OFS_CFG) begin
        cfg <= PWDATA[1:0];
      end
      if (wr && PADDR == OFS_COUNT) begin
        count <= PWDATA[CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // DMA handshake
  // ----------------------------------------------------------------
  assign last = (left <= CNT_RST);
  assign hw_done = CE & (state == DMA_HOLD) & ~DMA_ACK & last;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= DMA_IDLE;
      left <= CNT_RST;
    end else if (CE) begin
      unique case (state)
        DMA_IDLE: begin
          if (wr && PADDR == OFS_PTR_LO && hi.dma_en) begin
            state <= DMA_WAIT; // RL4
            left <= count;
          end
        end
        DMA_WAIT: begin
          if (!hi.dma_en && !DMA_ACK) begin
            state <= DMA_IDLE;
          end else if (DMA_ACK) begin
            state <= DMA_HOLD;
          end
        end
        DMA_HOLD: begin
          if (!DMA_ACK) begin
            if (!hi.dma_en || last) begin
              state <= DMA_IDLE; // RL6
            end else begin
              state <= DMA_WAIT;
              left <= left - 12'h001;
            end
          end
        end
      endcase
    end
  end

  // Request gated by the live enable so a clear drops it the same cycle
  assign DMA_REQ = (state == DMA_WAIT) & hi.dma_en; // RL4 RL5

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DMA_DOUT <= '0;
    end else if (CE) begin
      if (dma_xfer && hi.dir) begin
        DMA_DOUT.data <= rword; // RL14 RL18
      end
      DMA_DOUT.oe <= hi.dir & (dma_xfer | (state == DMA_HOLD && DMA_ACK));
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign done_src = ~hi.dma_en; // RL7
  assign done_evt = en_q & done_src;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      en_q <= 1'b0;
      status <= INT_RST;
      int_en <= INT_RST;
    end else if (CE) begin
      en_q <= hi.dma_en;
      // Set beats a clear in the same cycle
      if (done_evt) begin
        status[INT_DMA_DONE] <= 1'b1; // RL9
      end else if (wr && PADDR == OFS_CLEAR) begin
        status <= status & ~PWDATA[INT_W-1:0];
      end
      if (wr && PADDR == OFS_CMD && PWDATA[7:0] == CMD_CLR_DMA_MASK) begin
        int_en[INT_DMA_DONE] <= 1'b0; // RL16
      end else if (wr && PADDR == OFS_ENABLE) begin
        int_en <= PWDATA[INT_W-1:0];
      end
    end
  end

  assign IRQ = |(status & int_en); // RL9

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    unique case (PADDR)
      OFS_PTR_HI: rdata[7:0] = {hi.dir, hi.adv, 2'b00, hi.dma_en,
                                hi.upper}; // RL3
      OFS_PTR_LO: rdata[7:0] = lo;
      OFS_DATA: rdata[15:0] = hi.dir ? rword : 16'h0000;
      OFS_CFG: rdata[1:0] = cfg;
      OFS_STATUS: rdata[INT_W-1:0] = status;
      OFS_ENABLE: rdata[INT_W-1:0] = int_en;
      OFS_COUNT: rdata[CNT_W-1:0] = count;
      OFS_CMD, OFS_CLEAR: rdata = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  // Captured in setup so the access phase shows pre-step data
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= rdata;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_req_blocked: assert property ( // RL5
    @(posedge CORE_CLK) disable iff (!RSTN)
    !hi.dma_en |-> !DMA_REQ)
    else $error("DMA request while enable is clear");

  a_req_start: assert property ( // RL4
    @(posedge CORE_CLK) disable iff (!RSTN)
    (state == DMA_IDLE && wr && PADDR == OFS_PTR_LO && hi.dma_en &&
     !(wr && PADDR == OFS_PTR_HI)) |=> DMA_REQ)
    else $error("No DMA request after low pointer write");

  a_done_sticky: assert property ( // RL7
    @(posedge CORE_CLK) disable iff (!RSTN)
    (CE && $fell(hi.dma_en)) |=> status[INT_DMA_DONE])
    else $error("Done status not set when enable fell");

  a_done_irq: assert property ( // RL9
    @(posedge CORE_CLK) disable iff (!RSTN)
    (hw_done && int_en[INT_DMA_DONE] && !wr) |=> ##1 IRQ)
    else $error("Finished DMA raised no interrupt");

  a_hw_clear: assert property ( // RL8
    @(posedge CORE_CLK) disable iff (!RSTN)
    (hw_done && !(wr && PADDR == OFS_PTR_HI)) |=> !hi.dma_en)
    else $error("Enable not cleared on DMA completion");

  a_abort_end: assert property ( // RL6
    @(posedge CORE_CLK) disable iff (!RSTN)
    (CE && state == DMA_HOLD && !hi.dma_en && !DMA_ACK)
    |=> state == DMA_IDLE)
    else $error("Aborted DMA did not end after ack fall");

  a_step_byte: assert property ( // RL17
    @(posedge CORE_CLK) disable iff (!RSTN)
    (dma_xfer && hi.adv && !cfg.wide && !wr)
    |=> ptr == $past(ptr) + 11'h001)
    else $error("Pointer did not step by one");

  a_step_hold: assert property ( // RL2
    @(posedge CORE_CLK) disable iff (!RSTN)
    (xfer && !hi.adv && !wr) |=> $stable(ptr))
    else $error("Pointer moved with stepping off");

  a_cmd_mask: assert property ( // RL16
    @(posedge CORE_CLK) disable iff (!RSTN)
    (wr && PADDR == OFS_CMD && PWDATA[7:0] == CMD_CLR_DMA_MASK)
    |=> !int_en[INT_DMA_DONE] && !IRQ)
    else $error("Mask command left interrupt enabled");

  a_dma_read: assert property ( // RL18
    @(posedge CORE_CLK) disable iff (!RSTN)
    (dma_xfer && hi.dir) |=> DMA_DOUT.data == $past(rword)
    && DMA_DOUT.oe)
    else $error("DMA read data not presented");

  // Word steps keep the swap bit; a lost carry would reuse a word
  a_step_word: assert property ( // RL12
    @(posedge CORE_CLK) disable iff (!RSTN)
    (xfer && hi.adv && cfg.wide &&
     !(wr && (PADDR == OFS_PTR_HI || PADDR == OFS_PTR_LO)))
    |=> ptr[ADDR_W-1:1] == $past(ptr[ADDR_W-1:1]) + 10'h001 &&
        ptr[0] == $past(ptr[0]))
    else $error("Wide step moved swap bit or skipped a word");

  a_oe_release: assert property ( // RL18
    @(posedge CORE_CLK) disable iff (!RSTN)
    (CE && state == DMA_HOLD && !DMA_ACK) |=> !DMA_DOUT.oe)
    else $error("DMA data left driven after ack fall");
endmodule

// ### common/rpd_pkg.sv
// How it works
// RL1 - Upper pointer bit 7 set: next RAM access reads; clear: it writes.
// RL2 - Bit 6 set steps the pointer after each data access; clear holds it.
// RL3 - Upper pointer bits 5 and 4 are reserved; they read as zero here.
// RL4 - DMA enable bit 3 resets to 0; lower pointer write then raises request.
// RL5 - Clearing DMA enable mid-transfer drops the request pin at once.
// RL6 - After such a clear, DMA ends right after the next acknowledge fall.
// RL7 - DMA done interrupt source is the inverse of the DMA enable bit.
// RL8 - Hardware clears DMA enable itself when a DMA transfer completes.
// RL9 - Finished DMA raises the interrupt unless its enable bit blocks it.
// RL10 - Upper pointer bits 2..0 give RAM address bits 10..8.
// RL11 - Lower pointer bits 7..0 give RAM address bits 7..0.
// RL12 - With wide bus selected, lower pointer bit 0 becomes the lane swap bit.
// RL13 - Swap bit is undefined after reset; host writes it before wide select.
// RL14 - Lane swap applies to processor cycles and DMA cycles alike.
// RL15 - Strobe mode, swap 0: odd byte high lane; data strobe mode inverts.
// RL16 - Command 0x10 clears the DMA done interrupt enable, dropping the irq.
// RL17 - Pointer is one 11-bit address; stepping carries and wraps at 2048.
// RL18 - Each acknowledged DMA cycle moves data at the pointer like host access.
package rpd_pkg;
  localparam int ADDR_W = 11;
  localparam int APB_AW = 8;
  localparam int CNT_W = 12;
  localparam logic [APB_AW-1:0] OFS_PTR_HI = 8'h00;
  localparam logic [APB_AW-1:0] OFS_PTR_LO = 8'h04;
  localparam logic [APB_AW-1:0] OFS_DATA = 8'h08;
  localparam logic [APB_AW-1:0] OFS_CMD = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_CFG = 8'h10;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h14;
  localparam logic [APB_AW-1:0] OFS_CLEAR = 8'h18;
  localparam logic [APB_AW-1:0] OFS_ENABLE = 8'h1C;
  localparam logic [APB_AW-1:0] OFS_COUNT = 8'h20;
  localparam logic [7:0] CMD_CLR_DMA_MASK = 8'h10;
  localparam int INT_W = 1;
  localparam int INT_DMA_DONE = 0;
  localparam logic [INT_W-1:0] INT_RST = 1'h0;
  localparam logic [7:0] LO_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h001;

  typedef struct packed {
    logic dir;
    logic adv;
    logic [1:0] rsvd;
    logic dma_en;
    logic [2:0] upper;
  } rpd_hi_t;

  typedef struct packed {
    logic ds_mode;
    logic wide;
  } rpd_cfg_t;

  typedef struct packed {
    logic [15:0] data;
    logic oe;
  } rpd_dbus_t;

  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_WAIT = 3'b010,
    DMA_HOLD = 3'b100
  } rpd_dma_t;

  localparam rpd_hi_t HI_RST = '0;
  localparam rpd_cfg_t CFG_RST = '0;
endpackage

// ### tb/rpd_dmac.sv
`timescale 1ns/1ps
module rpd_dmac (
  input wire logic clk,            // Core clock
  input wire logic rst_n,          // Async reset, low
  input wire logic req,            // Request pin
  input wire logic [3:0] hold_len, // Ack high cycles minus one
  input wire logic [15:0] wdata,   // Word offered on writes
  output logic ack,                // Acknowledge pin
  output logic [15:0] din          // Data lines toward block
);
  logic [3:0] cnt;
  logic tgl;
  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // Long holds let software abort inside one acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt <= 4'h0;
    end else if (ack) begin
      cnt <= cnt + 4'h1;
      if (cnt == hold_len) begin
        ack <= 1'b0;
      end
    end else if (req) begin
      ack <= 1'b1;
      cnt <= 4'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl <= 1'b0;
    end else begin
      tgl <= ~tgl;
    end
  end
  // Released lines never echo the offered word
  assign din = ack ? wdata : ~wdata ^ {tgl, 15'h0};
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rpd_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dma_req;
  logic dma_ack;
  logic [15:0] dma_din;
  rpd_dbus_t dma_dout;
  logic irq;
  logic ce = 1'b1;
  logic [3:0] hold_len = 4'h1;
  logic [31:0] rd;
  logic perr;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  rpd_top i_rpd_top (.CORE_CLK(clk), .RSTN(rst_n), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DMA_REQ(dma_req), .DMA_ACK(dma_ack),
    .DMA_DIN(dma_din), .DMA_DOUT(dma_dout), .IRQ(irq));
  rpd_dmac i_rpd_dmac (.clk(clk), .rst_n(rst_n), .req(dma_req),
    .hold_len(hold_len), .wdata(16'h3C5A), .ack(dma_ack), .din(dma_din));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (dma_ack !== lvl && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("ack wait", {31'h0, dma_ack}, {31'h0, lvl});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc("ptr hi", OFS_PTR_HI, 32'h0);
    rdc("ptr lo", OFS_PTR_LO, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk("slverr", {31'h0, perr}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    chk("pready", {31'h0, pready}, 32'h1);
    ce <= 1'b0;
    wr(OFS_PTR_LO, 32'h5A);
    ce <= 1'b1;
    rdc("frozen lo", OFS_PTR_LO, 32'h0);
  endtask
  task automatic t_seq;
    wr(OFS_PTR_HI, 32'h47);
    wr(OFS_PTR_LO, 32'hFE);
    wr(OFS_DATA, 32'hA1);
    wr(OFS_DATA, 32'hB2);
    wr(OFS_DATA, 32'hC3);
    rdc("wrap lo", OFS_PTR_LO, 32'h01);
    rdc("wrap hi", OFS_PTR_HI, 32'h40);
    wr(OFS_PTR_HI, 32'hC7);
    wr(OFS_PTR_LO, 32'hFE);
    rdc("ram 7FE", OFS_DATA, 32'hA1);
    rdc("ram 7FF", OFS_DATA, 32'hB2);
    rdc("ram 000", OFS_DATA, 32'hC3);
    wr(OFS_PTR_HI, 32'h40);
    wr(OFS_PTR_LO, 32'hFF);
    wr(OFS_DATA, 32'hD4);
    wr(OFS_DATA, 32'hE5);
    wr(OFS_PTR_HI, 32'h81);
    wr(OFS_PTR_LO, 32'h00);
    rdc("ram 100", OFS_DATA, 32'hE5);
    rdc("no step", OFS_DATA, 32'hE5);
  endtask
  task automatic t_lanes;
    wr(OFS_PTR_HI, 32'h40);
    wr(OFS_PTR_LO, 32'h20);
    wr(OFS_DATA, 32'h11);
    wr(OFS_DATA, 32'h22);
    wr(OFS_PTR_HI, 32'h80);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_PTR_LO, 32'h20 | m[0]);
      wr(OFS_CFG, {30'h0, m[1], 1'b1});
      rdc("lanes", OFS_DATA, (m[0] ^ m[1]) ? 32'h1122 : 32'h2211);
      wr(OFS_CFG, 32'h0);
    end
    wr(OFS_PTR_HI, 32'h40);
    wr(OFS_PTR_LO, 32'h30);
    wr(OFS_CFG, 32'h1);
    wr(OFS_DATA, 32'hABCD);
    rdc("wide step", OFS_PTR_LO, 32'h32);
    wr(OFS_CFG, 32'h0);
    wr(OFS_PTR_HI, 32'h80);
    wr(OFS_PTR_LO, 32'h31);
    rdc("wide odd", OFS_DATA, 32'hAB);
    wr(OFS_PTR_LO, 32'h30);
    rdc("wide even", OFS_DATA, 32'hCD);
  endtask
  task automatic t_dma_read;
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_CFG, 32'h1);
    wr(OFS_PTR_HI, 32'h88);
    wr(OFS_PTR_LO, 32'h21);
    wait_ack(1'b1);
    #1;
    chk("req in ack", {31'h0, dma_req}, 32'h0);
    chk("dma out", {15'h0, dma_dout}, {15'h0, 16'h1122, 1'b1});
    wait_ack(1'b0);
    repeat (3) @(posedge clk);
    rdc("hw clear", OFS_PTR_HI, 32'h80);
    rdc("done", OFS_STATUS, 32'h1);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(OFS_CMD, {24'h0, CMD_CLR_DMA_MASK});
    chk("irq off", {31'h0, irq}, 32'h0);
    rdc("mask", OFS_ENABLE, 32'h0);
  endtask
  task automatic t_dma_write;
    int n;
    wr(OFS_CLEAR, 32'h1);
    wr(OFS_CFG, 32'h0);
    wr(OFS_COUNT, 32'h3);
    wr(OFS_PTR_HI, 32'h48);
    wr(OFS_PTR_LO, 32'h40);
    rd = 32'h0;
    n = 0;
    while (rd[0] !== 1'b1 && n < 40) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    chk("done wait", rd, 32'h1);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rdc("dma ptr", OFS_PTR_LO, 32'h43);
    wr(OFS_PTR_HI, 32'hC0);
    wr(OFS_PTR_LO, 32'h40);
    repeat (3) rdc("dma ram", OFS_DATA, 32'h5A);
  endtask
  task automatic t_abort;
    logic seen;
    wr(OFS_CLEAR, 32'h1);
    wr(OFS_ENABLE, 32'h1);
    hold_len <= 4'h7;
    wr(OFS_PTR_HI, 32'h88);
    wr(OFS_PTR_LO, 32'h00);
    wait_ack(1'b1);
    wr(OFS_PTR_HI, 32'h80);
    wait_ack(1'b0);
    seen = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1;
      seen = seen | dma_req;
    end
    @(posedge clk);
    chk("no rerequest", {31'h0, seen}, 32'h0);
    rdc("abort done", OFS_STATUS, 32'h1);
    chk("abort irq", {31'h0, irq}, 32'h1);
  endtask
  // ----------------------------------------
  // Run
  // ----------------------------------------
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_seq;
    t_lanes;
    t_dma_read;
    t_dma_write;
    t_abort;
    report_and_stop;
  end
endmodule
